// >>> core/kwd_pkg.sv
package kwd_pkg;

  // ----------------------------------------------------------------
  // counter geometry and timing, in machine cycles
  // ----------------------------------------------------------------
  localparam int KWD_CNT_W = 22;
  localparam int KWD_OVF_CYCLES = 4194304;
  localparam int KWD_RELOAD_W = 7;
  localparam int KWD_PULSE_EXP = 15;
  localparam int KWD_PULSE_CYCLES = 32768;
  localparam int KWD_MC_DIV = 12;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] KWD_RELOAD_ADDR = 8'ha6;
  localparam logic [7:0] KWD_STATUS_ADDR = 8'ha7;
  localparam logic [7:0] KWD_CNT0_ADDR = 8'ha8;
  localparam logic [7:0] KWD_CNT1_ADDR = 8'ha9;
  localparam logic [7:0] KWD_CNT2_ADDR = 8'haa;
  localparam logic [7:0] KWD_KEY_ADDR = 8'hae;

  // ----------------------------------------------------------------
  // field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0] KWD_DISABLE_KEY = 8'h55;
  localparam logic [7:0] KWD_KEY_RESET = 8'h00;
  localparam int KWD_ST_EN_BIT = 0;
  localparam int KWD_ST_WDR_BIT = 1;

  // ----------------------------------------------------------------
  // control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KWD_ARMED = 3'b001,
    KWD_HALTED = 3'b010,
    KWD_FIRING = 3'b100
  } kwd_state_t;

endpackage

// >>> core/kwd_tick_div.sv
`timescale 1ns/10ps
module kwd_tick_div
#(
  parameter int DIV = 12
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // machine-cycle strobe
  output logic tick_o
);

  localparam int DW = $clog2(DIV);

  logic [DW-1:0] cnt;

  // ----------------------------------------------------------------
  // divider: one strobe per DIV clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt == DW'(DIV - 1));
      if (cnt == DW'(DIV - 1))
        cnt <= '0;
      else
        cnt <= cnt + DW'(1);
    end
  end

endmodule

// >>> core/kwd_pulse_stretch.sv
`timescale 1ns/10ps
module kwd_pulse_stretch
#(
  parameter int LEN = 32768
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // timing strobe and trigger
  input wire logic tick_i,
  input wire logic start_i,
  // stretched level
  output logic busy_o
);

  localparam int PW = $clog2(LEN) + 1;

  logic [PW-1:0] cnt;

  // ----------------------------------------------------------------
  // holds busy for LEN strobes after a start
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= '0;
      busy_o <= 1'b0;
    end
    else if (start_i && !busy_o)
    begin
      cnt <= '0;
      busy_o <= 1'b1;
    end
    else if (busy_o && tick_i)
    begin
      if (cnt == PW'(LEN - 1))
        busy_o <= 1'b0;
      cnt <= cnt + PW'(1);
    end
  end

endmodule

// >>> core/kwd_watchdog.sv
`timescale 1ns/10ps
module kwd_watchdog
  import kwd_pkg::*;
#(
  parameter int CNT_W = KWD_CNT_W,
  parameter int PULSE_CYCLES = KWD_PULSE_CYCLES,
  parameter int MC_DIV = KWD_MC_DIV
)
(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // reset and status
  output logic INT_RST_O,
  output logic WDG_ENABLED_O
);

  localparam int LOW_W = CNT_W - KWD_RELOAD_W;

  // ----------------------------------------------------------------
  // internal signals
  // ----------------------------------------------------------------
  logic mc_tick;
  logic pulse_busy;
  logic int_rst;
  logic [CNT_W-1:0] overflow_guard_timer;
  logic [CNT_W-1:0] next_timer;
  logic [7:0] guard_key_register;
  logic enabled;
  logic overflow;
  logic reload_wr;
  logic key_wr;
  logic status_wr;
  logic wdr_flag;
  logic [23:0] cnt_wide;
  logic [15:0] snap;
  logic [7:0] next_rdata;
  kwd_state_t state;
  kwd_state_t next_state;

  // ----------------------------------------------------------------
  // machine-cycle strobe and reset pulse
  // ----------------------------------------------------------------
  // the divider runs from the external reset only, so the machine
  // cycle keeps its rhythm through a watchdog reset
  kwd_tick_div #(
    .DIV(MC_DIV)
  ) u_tick (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .tick_o(mc_tick)
  );

  // the stretcher must not be cleared by the reset it makes
  kwd_pulse_stretch #(
    .LEN(PULSE_CYCLES)
  ) u_pulse (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .tick_i(mc_tick),
    .start_i(overflow),
    .busy_o(pulse_busy)
  );

  // one internal reset shared by every source
  assign int_rst = SYS_RST_I | pulse_busy;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign reload_wr = REG_WR_I && (REG_ADDR_I == KWD_RELOAD_ADDR);
  assign key_wr = REG_WR_I && (REG_ADDR_I == KWD_KEY_ADDR);
  assign status_wr = REG_WR_I && (REG_ADDR_I == KWD_STATUS_ADDR);

  // ----------------------------------------------------------------
  // key register
  // ----------------------------------------------------------------
  // reset value is not the disable pattern, so the guard runs
  always_ff @(posedge REF_CLK_I)
  begin
    if (int_rst)
      guard_key_register <= KWD_KEY_RESET;
    else if (key_wr)
      guard_key_register <= REG_WDATA_I;
  end

  // only the one exact pattern stops counting
  assign enabled = (guard_key_register != KWD_DISABLE_KEY);

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      KWD_ARMED:
      begin
        if (overflow)
          next_state = KWD_FIRING;
        else if (!enabled)
          next_state = KWD_HALTED;
      end
      KWD_HALTED:
      begin
        if (enabled)
          next_state = KWD_ARMED;
      end
      KWD_FIRING:
      begin
        if (!pulse_busy && !overflow)
          next_state = KWD_ARMED;
      end
      default:
        next_state = KWD_ARMED;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      state <= KWD_ARMED;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // overflow detection
  // ----------------------------------------------------------------
  // last state of the full range reached and the next step would wrap;
  // a reload in the same cycle is the service and wins
  assign overflow = (state == KWD_ARMED) && enabled && mc_tick &&
                    !reload_wr && (&overflow_guard_timer);

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always_comb
  begin
    next_timer = overflow_guard_timer;
    if (reload_wr)
      // low bits cleared, so zero clears everything
      next_timer = {REG_WDATA_I[KWD_RELOAD_W-1:0], {LOW_W{1'b0}}};
    else if (enabled && mc_tick)
      next_timer = overflow_guard_timer + CNT_W'(1);
  end

  // no idle input: the counter ignores the processor's sleep
  always_ff @(posedge REF_CLK_I)
  begin
    if (int_rst)
      overflow_guard_timer <= '0;
    else
      overflow_guard_timer <= next_timer;
  end

  // ----------------------------------------------------------------
  // reset cause flag
  // ----------------------------------------------------------------
  // survives the internal reset so boot code can tell why it started;
  // an overflow beats a clear in the same cycle
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      wdr_flag <= 1'b0;
    else if (overflow)
      wdr_flag <= 1'b1;
    else if (status_wr && REG_WDATA_I[KWD_ST_WDR_BIT])
      wdr_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // counter snapshot
  // ----------------------------------------------------------------
  // reading the low byte freezes the upper bytes, so a multi-byte
  // read is coherent even while the counter moves
  assign cnt_wide = 24'(overflow_guard_timer);

  always_ff @(posedge REF_CLK_I)
  begin
    if (int_rst)
      snap <= '0;
    else if (REG_RD_I && (REG_ADDR_I == KWD_CNT0_ADDR))
      snap <= cnt_wide[23:8];
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    if (REG_RD_I)
    begin
      unique case (REG_ADDR_I)
        KWD_KEY_ADDR:
          next_rdata = guard_key_register;
        KWD_STATUS_ADDR:
        begin
          next_rdata[KWD_ST_EN_BIT] = enabled;
          next_rdata[KWD_ST_WDR_BIT] = wdr_flag;
        end
        KWD_CNT0_ADDR:
          next_rdata = cnt_wide[7:0];
        KWD_CNT1_ADDR:
          next_rdata = snap[7:0];
        KWD_CNT2_ADDR:
          next_rdata = snap[15:8];
        // reload register is write-only and unmapped reads give zero
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge REF_CLK_I)
  begin
    if (int_rst)
      REG_RDATA_O <= 8'h00;
    else
      REG_RDATA_O <= next_rdata;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // registered copy of the shared reset; lags the source by one clock
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      INT_RST_O <= 1'b1;
    else
      INT_RST_O <= pulse_busy;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (int_rst)
      WDG_ENABLED_O <= 1'b1;
    else
      WDG_ENABLED_O <= (next_state != KWD_HALTED);
  end

endmodule

// >>> tb/kwd_watchdog_sva.sv
`timescale 1ns/10ps
module kwd_watchdog_sva
  import kwd_pkg::*;
#(
  parameter int PULSE_CYCLES = 4,
  parameter int MC_DIV = 12
)
(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // bus
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  // status
  input wire logic INT_RST_O,
  input wire logic WDG_ENABLED_O
);
  int len;
  logic key_wr;
  assign key_wr = REG_WR_I && REG_ADDR_I == KWD_KEY_ADDR;
  // pulse length so far; the tick phase makes it up to one tick short
  always_ff @(posedge REF_CLK_I)
    if (SYS_RST_I || !INT_RST_O)
      len <= 0;
    else
      len <= len + 1;
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  rst_release_a: assert property (
    $fell(SYS_RST_I) |-> INT_RST_O ##1 !INT_RST_O)
    else $error("reset release wrong");
  run_at_rst_a: assert property (
    $fell(SYS_RST_I) |-> WDG_ENABLED_O)
    else $error("not enabled after reset");
  key_off_a: assert property (
    key_wr && REG_WDATA_I == KWD_DISABLE_KEY && !INT_RST_O
      |-> ##[1:2] (!WDG_ENABLED_O || INT_RST_O))
    else $error("key did not disable");
  key_on_a: assert property (
    key_wr && REG_WDATA_I != KWD_DISABLE_KEY |-> ##[1:2] WDG_ENABLED_O)
    else $error("key did not enable");
  quiet_off_a: assert property (
    (!WDG_ENABLED_O && !INT_RST_O)[*3] |=> !INT_RST_O)
    else $error("reset while disabled");
  pulse_min_a: assert property (
    $fell(INT_RST_O) && len > 1 |-> len >= PULSE_CYCLES * MC_DIV - MC_DIV)
    else $error("reset pulse short");
  pulse_max_a: assert property (
    INT_RST_O |-> len < PULSE_CYCLES * MC_DIV + 1)
    else $error("reset pulse long");
  rdata_zero_a: assert property (
    !$past(REG_RD_I) || $past(REG_ADDR_I) == KWD_RELOAD_ADDR
      |-> REG_RDATA_O == 8'h00)
    else $error("read data not zero");
endmodule

// >>> tb/kwd_watchdog_tb.sv
`timescale 1ns/10ps
module kwd_watchdog_tb;
  import kwd_pkg::*;
  // short counts keep the run brief
  localparam int CW = 10;
  // service values stay inside 00h..7Eh; bit 7 is reserved
  localparam logic [7:0] RV[5] = '{8'h01, 8'h7e, 8'h00, 8'h55, 8'h2a};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic irst;
  logic wen;
  logic [7:0] expq[$];
  int miscompares = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  kwd_watchdog #(.CNT_W(CW), .PULSE_CYCLES(4), .MC_DIV(12)) dut (
    .REF_CLK_I(clk),
    .SYS_RST_I(rst),
    .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata),
    .REG_WR_I(wr),
    .REG_RD_I(rd),
    .REG_RDATA_O(rdata),
    .INT_RST_O(irst),
    .WDG_ENABLED_O(wen)
  );
  // ---
  // checking
  // ---
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rd_q)
      check("rdata", 32'(rdata), 32'(expq.pop_front()));
    rd_q <= rd;
  end
  // each signal is set once per edge, so back to back cycles never race
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd_exp(input logic [7:0] a, e);
    expq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wait_rst(input logic lvl, input int lim, output int d);
    d = 0;
    while (irst !== lvl && d < lim)
    begin
      @(posedge clk);
      #1;
      d++;
    end
    if (d >= lim)
    begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic ovf(input logic [7:0] v);
    int n;
    int d;
    n = (1 << CW) - (int'(v) << (CW - 7)) - 1;
    bus(1'b1, 1'b0, KWD_KEY_ADDR, 8'h33);
    bus(1'b1, 1'b0, KWD_RELOAD_ADDR, v);
    wr <= 1'b0;
    wait_rst(1'b1, 13000, d);
    check("ovf", 32'(d > n * 12 + 1 && d < n * 12 + 16), 1);
    wait_rst(1'b0, 100, d);
    check("enabled", 32'(wen), 1);
    rd_exp(KWD_KEY_ADDR, 8'h00);
    // cause flag survives the pulse; clearing it leaves only enabled
    rd_exp(KWD_STATUS_ADDR, 8'h03);
    bus(1'b1, 1'b0, KWD_STATUS_ADDR, 8'h02);
    rd_exp(KWD_STATUS_ADDR, 8'h01);
  endtask
  initial
  begin
    logic [7:0] k;
    void'($urandom(44949));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("enabled", 32'(wen), 1);
    rd_exp(KWD_KEY_ADDR, 8'h00);
    rd_exp(KWD_RELOAD_ADDR, 8'h00);
    rd_exp(8'h3c, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      k = (i == 0) ? KWD_DISABLE_KEY : 8'($urandom);
      bus(1'b1, 1'b0, KWD_KEY_ADDR, k);
      rd_exp(KWD_KEY_ADDR, k);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check("enabled", 32'(wen), 32'(k != KWD_DISABLE_KEY));
    end
    // let a few ticks land in the low bits, then freeze and reload
    bus(1'b1, 1'b0, KWD_KEY_ADDR, 8'h00);
    repeat (40) bus(1'b0, 1'b0, 8'h00, 8'h00);
    bus(1'b1, 1'b0, KWD_KEY_ADDR, KWD_DISABLE_KEY);
    foreach (RV[i])
    begin
      bus(1'b1, 1'b0, KWD_RELOAD_ADDR, RV[i]);
      k = 8'(16'(RV[i] & 8'h7f) << (CW - 7));
      rd_exp(KWD_CNT0_ADDR, k);
      rd_exp(KWD_CNT1_ADDR, 8'(16'(RV[i] & 8'h7f) >> (15 - CW)));
      rd_exp(KWD_CNT2_ADDR, 8'h00);
    end
    ovf(8'h7e);
    ovf(8'h00);
    bus(1'b1, 1'b0, KWD_KEY_ADDR, KWD_DISABLE_KEY);
    bus(1'b1, 1'b0, KWD_RELOAD_ADDR, 8'h7e);
    repeat (300) bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    check("reset", 32'(irst), 0);
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
bind kwd_watchdog kwd_watchdog_sva #(
  .PULSE_CYCLES(PULSE_CYCLES),
  .MC_DIV(MC_DIV)
) u_sva (
  .REF_CLK_I(REF_CLK_I),
  .SYS_RST_I(SYS_RST_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O),
  .INT_RST_O(INT_RST_O),
  .WDG_ENABLED_O(WDG_ENABLED_O)
);
